// ===== rtl/spb_serial_port.sv
// serial port receive status, baud control and baud rate generator with apb registers
`timescale 1ns/100ps
`default_nettype none
`include "spb_defs.svh"

module spb_serial_port (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rx_pin,
  input wire logic tx_line,
  output logic tx_pin,
  input wire logic sclk_in,
  output logic sclk_seen,
  output logic sclk_out,
  output logic sclk_oe_n,
  output logic rx_data_ready,
  output logic wake_event
);
  // ****************************************************************
  // helpers
  // ****************************************************************
  // generator ticks per bit for the current mode
  function automatic logic [6:0] bit_ticks(input logic sync, input logic hs, input logic wide);
    logic [6:0] k;
    k = `SPB_DIV_FAST;
    if (sync) begin
      k = `SPB_DIV_SYNC;
    end else if (!hs && !wide) begin
      k = `SPB_DIV_SLOW;
    end else if (hs && wide) begin
      k = `SPB_DIV_SYNC;
    end else begin
      k = `SPB_DIV_FAST;
    end
    return k;
  endfunction : bit_ticks

  // log2 of generator ticks per eight bits, for autobaud scaling
  function automatic logic [4:0] eight_bit_shift(input logic [6:0] k);
    logic [4:0] s;
    s = 5'h05;
    if (k == `SPB_DIV_SLOW) begin
      s = 5'h09;
    end else if (k == `SPB_DIV_FAST) begin
      s = 5'h07;
    end
    return s;
  endfunction : eight_bit_shift

  // two of three vote
  function automatic logic majority(input logic [2:0] v);
    return (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction : majority

  spb_pkg::spb_state_s s_reg;
  spb_pkg::spb_state_s s_next;

  logic wr_en;
  logic rd_en;
  logic setup;
  logic [15:0] divisor;
  logic [6:0] k_ticks;
  logic [6:0] k_half;
  logic brg_tick;
  logic div_write;
  logic rxd;
  logic fall;
  logic rise;
  logic bit_end;
  logic vote;
  logic [25:0] ab_scaled;
  logic [7:0] rs_word;
  logic [7:0] bc_word;
  logic [7:0] tc_word;

  // ****************************************************************
  // bus strobes and derived levels
  // ****************************************************************
  // zero wait state; read data is captured in the setup cycle
  assign pready = 1'b1;
  assign setup = psel & ~penable;
  assign wr_en = psel & penable & pwrite & pstrb[0];
  assign rd_en = psel & penable & ~pwrite;
  assign div_write = wr_en & ((paddr == `SPB_OFF_DIV_LOW) | (paddr == `SPB_OFF_DIV_HIGH));
  assign divisor = s_reg.wide ? {s_reg.div_hi, s_reg.div_lo} : {8'h00, s_reg.div_lo};
  assign k_ticks = bit_ticks(s_reg.sync_mode, s_reg.high_speed, s_reg.wide);
  assign k_half = {1'b0, k_ticks[6:1]};
  assign brg_tick = (s_reg.brg_cnt == 16'h0000) & ~div_write;
  assign rxd = rx_pin ^ (s_reg.rx_inv & ~s_reg.sync_mode);
  assign fall = s_reg.rx_prev & ~rxd;
  assign rise = ~s_reg.rx_prev & rxd;
  assign bit_end = brg_tick & (s_reg.phase == k_ticks - 7'h01);
  assign vote = majority(s_reg.samp);
  // count taken inclusive of the closing edge, so an exact rate yields its exact divisor
  assign ab_scaled = (s_reg.ab_cnt + 26'h0000001) >> eight_bit_shift(k_ticks);
  assign rs_word = {1'b0, s_reg.nine_sel, 1'b0, s_reg.continuous_receive_enable, s_reg.address_detect_enable,
                    s_reg.framing_error_flag, s_reg.overrun_error_flag, s_reg.buf_ninth};
  assign bc_word = {s_reg.autobaud_rollover_flag, (s_reg.st == spb_pkg::SPB_IDLE), s_reg.rx_inv, s_reg.tx_inv,
                    s_reg.wide, 1'b0, s_reg.wakeup_on_break_enable, s_reg.autobaud_enable};
  assign tc_word = {s_reg.master, 2'b00, s_reg.sync_mode, 1'b0, s_reg.high_speed, 2'b00};

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_next = s_reg;
    s_next.wake_pulse = 1'b0;
    s_next.rx_prev = rxd;
    s_next.txd = tx_line ^ (s_reg.tx_inv & ~s_reg.sync_mode);

    // read data captured in setup so the answer comes from flops
    if (setup) begin
      s_next.pslverr = 1'b0;
      s_next.prdata = 32'h0000_0000;
      if (paddr == `SPB_OFF_RX_STATUS) begin
        s_next.prdata = {24'h000000, rs_word};
      end else if (paddr == `SPB_OFF_RX_DATA) begin
        s_next.prdata = {24'h000000, s_reg.buf_data};
      end else if (paddr == `SPB_OFF_TX_CONTROL) begin
        s_next.prdata = {24'h000000, tc_word};
      end else if (paddr == `SPB_OFF_BAUD_CONTROL) begin
        s_next.prdata = {24'h000000, bc_word};
      end else if (paddr == `SPB_OFF_DIV_LOW) begin
        s_next.prdata = {24'h000000, s_reg.div_lo};
      end else if (paddr == `SPB_OFF_DIV_HIGH) begin
        s_next.prdata = {24'h000000, s_reg.div_hi};
      end else begin
        s_next.pslverr = 1'b1;
      end
    end

    // a read of the data register empties the buffer
    if (rd_en && (paddr == `SPB_OFF_RX_DATA)) begin
      s_next.buf_full = 1'b0;
    end

    // software writes; flag sets by hardware below win over these
    if (wr_en) begin
      if (paddr == `SPB_OFF_RX_STATUS) begin
        s_next.nine_sel = pwdata[`SPB_RS_NINE_BIT];
        s_next.continuous_receive_enable = pwdata[`SPB_RS_CONTINUOUS_RECEIVE_ENABLE];
        s_next.address_detect_enable = pwdata[`SPB_RS_ADDRESS_DETECT_ENABLE];
        if (!pwdata[`SPB_RS_CONTINUOUS_RECEIVE_ENABLE]) begin
          s_next.overrun_error_flag = 1'b0;
          s_next.st = spb_pkg::SPB_IDLE;
        end
      end else if (paddr == `SPB_OFF_TX_CONTROL) begin
        s_next.master = pwdata[`SPB_TC_MASTER];
        s_next.sync_mode = pwdata[`SPB_TC_SYNC];
        s_next.high_speed = pwdata[`SPB_TC_HIGH_SPEED];
      end else if (paddr == `SPB_OFF_BAUD_CONTROL) begin
        s_next.autobaud_rollover_flag = pwdata[`SPB_BC_ROLLOVER];
        s_next.rx_inv = pwdata[`SPB_BC_RX_INV];
        s_next.tx_inv = pwdata[`SPB_BC_TX_INV];
        s_next.wide = pwdata[`SPB_BC_WIDE];
        s_next.wakeup_on_break_enable = pwdata[`SPB_BC_WAKE];
        s_next.autobaud_enable = pwdata[`SPB_BC_AUTOBAUD];
        s_next.ab_act = 1'b0;
      end else if (paddr == `SPB_OFF_DIV_LOW) begin
        s_next.div_lo = pwdata[7:0];
      end else if (paddr == `SPB_OFF_DIV_HIGH) begin
        s_next.div_hi = pwdata[7:0];
      end
    end

    // free-running generator, restarted by a divisor write
    if (div_write) begin
      s_next.brg_cnt = 16'h0000;
    end else if (brg_tick) begin
      s_next.brg_cnt = divisor;
    end else begin
      s_next.brg_cnt = s_reg.brg_cnt - 16'h0001;
    end

    // sync master clock: high in the second half of each bit
    if (brg_tick) begin
      s_next.sclk_ph = (s_reg.sclk_ph >= k_ticks - 7'h01) ? 7'h00 : s_reg.sclk_ph + 7'h01;
    end

    // wake on break: falling edge pulses the event for one cycle, rising edge ends the wake mode
    if (s_reg.wakeup_on_break_enable && !s_reg.sync_mode) begin
      if (fall) begin
        s_next.wake_pulse = 1'b1;
      end else if (rise) begin
        s_next.wakeup_on_break_enable = 1'b0;
      end
    end

    // autobaud: cycles from first to fifth falling edge span eight bits
    if (s_reg.autobaud_enable && !s_reg.sync_mode && !s_reg.wakeup_on_break_enable) begin
      if (!s_reg.ab_act) begin
        if (fall) begin
          s_next.ab_act = 1'b1;
          s_next.ab_falls = 3'h0;
          s_next.ab_cnt = 26'h0000000;
        end
      end else begin
        s_next.ab_cnt = s_reg.ab_cnt + 26'h0000001;
        if (ab_scaled[25:16] != 10'h000) begin
          // divisor would not fit: flag it and give up on this character
          s_next.autobaud_rollover_flag = 1'b1;
          s_next.autobaud_enable = 1'b0;
          s_next.ab_act = 1'b0;
        end else if (fall) begin
          s_next.ab_falls = s_reg.ab_falls + 3'h1;
          if (s_reg.ab_falls == `SPB_ABD_FALLS - 3'h1) begin
            s_next.div_lo = ab_scaled[7:0] - 8'h01;
            s_next.div_hi = ab_scaled[15:8] - {7'h00, (ab_scaled[7:0] == 8'h00)};
            s_next.autobaud_enable = 1'b0;
            s_next.ab_act = 1'b0;
            s_next.brg_cnt = 16'h0000;
          end
        end
      end
    end

    // asynchronous receiver, timed by generator ticks
    case (s_reg.st)
      spb_pkg::SPB_IDLE: begin
        if (s_reg.continuous_receive_enable && !s_reg.sync_mode && !s_reg.autobaud_enable && !s_reg.wakeup_on_break_enable && fall) begin
          s_next.st = spb_pkg::SPB_START;
          s_next.phase = 7'h00;
          s_next.bitn = 4'h0;
        end
      end
      default: begin
        if (brg_tick) begin
          s_next.phase = bit_end ? 7'h00 : s_reg.phase + 7'h01;
          // three samples straddling mid bit
          if (s_reg.phase == k_half - 7'h01) begin
            s_next.samp[0] = rxd;
          end
          if (s_reg.phase == k_half) begin
            s_next.samp[1] = rxd;
          end
          if (s_reg.phase == k_half + 7'h01) begin
            s_next.samp[2] = rxd;
          end
        end
        if (bit_end) begin
          case (s_reg.st)
            spb_pkg::SPB_START: begin
              // a high start vote is a glitch, not a frame
              s_next.st = vote ? spb_pkg::SPB_IDLE : spb_pkg::SPB_DATA;
            end
            spb_pkg::SPB_DATA: begin
              s_next.shreg = s_reg.nine_sel ? {vote, s_reg.shreg[8:1]}
                                            : {1'b0, vote, s_reg.shreg[8:2]};
              s_next.bitn = s_reg.bitn + 4'h1;
              if (s_reg.bitn == (s_reg.nine_sel ? 4'h8 : 4'h7)) begin
                s_next.st = spb_pkg::SPB_STOP;
              end
            end
            default: begin
              s_next.st = spb_pkg::SPB_IDLE;
              if (s_reg.address_detect_enable && s_reg.nine_sel && !s_reg.shreg[8]) begin
                // data frame while waiting for an address: dropped
                s_next.st = spb_pkg::SPB_IDLE;
              end else if (s_reg.buf_full && !(rd_en && (paddr == `SPB_OFF_RX_DATA))) begin
                s_next.overrun_error_flag = 1'b1;
              end else begin
                s_next.buf_data = s_reg.shreg[7:0];
                s_next.buf_ninth = s_reg.shreg[8];
                s_next.framing_error_flag = ~vote;
                s_next.buf_full = 1'b1;
              end
            end
          endcase
        end
      end
    endcase
  end

  // ****************************************************************
  // state register
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.st <= spb_pkg::SPB_IDLE;
      s_reg.rx_prev <= 1'b1;
      s_reg.txd <= 1'b1;
      s_reg.div_lo <= `SPB_RST_DIV;
      s_reg.div_hi <= `SPB_RST_DIV;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign prdata = s_reg.prdata;
  assign pslverr = s_reg.pslverr & psel & penable;
  assign tx_pin = s_reg.txd;
  assign rx_data_ready = s_reg.buf_full;
  assign wake_event = s_reg.wake_pulse;
  // clock polarity in sync modes; only a master drives the clock pin
  assign sclk_seen = sclk_in ^ s_reg.rx_inv;
  assign sclk_out = (s_reg.sclk_ph >= k_half) ^ s_reg.tx_inv;
  assign sclk_oe_n = ~(s_reg.sync_mode & s_reg.master);
endmodule : spb_serial_port
`default_nettype wire

// ===== rtl/spb_defs.svh
// register offsets, field positions, reset values and timing figures of the serial port block
`ifndef SPB_DEFS_SVH
`define SPB_DEFS_SVH
// ****************************************************************
// register byte offsets
// ****************************************************************
`define SPB_OFF_RX_STATUS 12'h000
`define SPB_OFF_RX_DATA 12'h004
`define SPB_OFF_TX_CONTROL 12'h008
`define SPB_OFF_BAUD_CONTROL 12'h00c
`define SPB_OFF_DIV_LOW 12'h010
`define SPB_OFF_DIV_HIGH 12'h014
// ****************************************************************
// receive status fields
// ****************************************************************
`define SPB_RS_NINE_BIT 6
`define SPB_RS_CONTINUOUS_RECEIVE_ENABLE 4
`define SPB_RS_ADDRESS_DETECT_ENABLE 3
`define SPB_RS_FRAMING_ERROR_FLAG 2
`define SPB_RS_OVERRUN_ERROR_FLAG 1
`define SPB_RS_NINTH 0
// ****************************************************************
// transmit control fields used by the baud logic
// ****************************************************************
`define SPB_TC_MASTER 7
`define SPB_TC_SYNC 4
`define SPB_TC_HIGH_SPEED 2
// ****************************************************************
// baud control fields
// ****************************************************************
`define SPB_BC_ROLLOVER 7
`define SPB_BC_IDLE 6
`define SPB_BC_RX_INV 5
`define SPB_BC_TX_INV 4
`define SPB_BC_WIDE 3
`define SPB_BC_WAKE 1
`define SPB_BC_AUTOBAUD 0
// ****************************************************************
// reset values and divide factors
// ****************************************************************
`define SPB_RST_BYTE 8'h00
`define SPB_RST_DIV 8'h00
`define SPB_DIV_SLOW 7'h40
`define SPB_DIV_FAST 7'h10
`define SPB_DIV_SYNC 7'h04
`define SPB_ABD_FALLS 3'h4
`endif

// ===== rtl/spb_pkg.sv
// types of the serial port baud and receive status block
package spb_pkg;
  // receiver sequence
  typedef enum logic [1:0] {
    SPB_IDLE,
    SPB_START,
    SPB_DATA,
    SPB_STOP
  } spb_rx_e;

  // whole state of the block
  typedef struct packed {
    spb_rx_e st;
    logic [6:0] phase;
    logic [2:0] samp;
    logic [3:0] bitn;
    logic [8:0] shreg;
    logic rx_prev;
    logic [7:0] buf_data;
    logic buf_ninth;
    logic buf_full;
    logic framing_error_flag;
    logic overrun_error_flag;
    logic nine_sel;
    logic continuous_receive_enable;
    logic address_detect_enable;
    logic sync_mode;
    logic high_speed;
    logic master;
    logic autobaud_rollover_flag;
    logic rx_inv;
    logic tx_inv;
    logic wide;
    logic wakeup_on_break_enable;
    logic autobaud_enable;
    logic [7:0] div_lo;
    logic [7:0] div_hi;
    logic [15:0] brg_cnt;
    logic ab_act;
    logic [2:0] ab_falls;
    logic [25:0] ab_cnt;
    logic [6:0] sclk_ph;
    logic wake_pulse;
    logic txd;
    logic [31:0] prdata;
    logic pslverr;
  } spb_state_s;
endpackage : spb_pkg

// ===== verif/spb_serial_port_assertions.sv
// concurrent checks on the ports of the serial port block
`timescale 1ns/100ps
`default_nettype none
module spb_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic tx_line,
  input wire logic tx_pin,
  input wire logic sclk_in,
  input wire logic sclk_seen,
  input wire logic sclk_oe_n,
  input wire logic rx_data_ready,
  input wire logic wake_event
);
  logic [7:0] bcm;
  logic [7:0] tcm;
  logic acc;
  logic wr;
  // ****************
  // register mirrors
  // ****************
  assign acc = psel && penable;
  assign wr = acc && pwrite && pstrb[0];
  // mirrors follow software writes only; hardware clears are not seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bcm <= 8'h00;
      tcm <= 8'h00;
    end else begin
      if (wr && paddr == 12'h00c) bcm <= pwdata[7:0];
      if (wr && paddr == 12'h008) tcm <= pwdata[7:0];
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_ZERO_WAIT: assert property (psel && !penable |=> pready)
    else $error("access phase not ready");
  AST_UNMAPPED: assert property (acc |-> pslverr == (paddr > 12'h014 || paddr[1:0] != 2'h0))
    else $error("error response wrong");
  AST_BC_READ: assert property (acc && !pwrite && paddr == 12'h00c |->
    prdata[5:2] == {bcm[5:3], 1'b0} && prdata[31:8] == 24'h0) else $error("baud control read");
  AST_TX_POL: assert property (tx_pin == ($past(tx_line) ^ ($past(bcm[4]) && !$past(tcm[4]))))
    else $error("transmit polarity wrong");
  AST_SCLK_SEEN: assert property (sclk_seen == (sclk_in ^ bcm[5]))
    else $error("clock polarity wrong");
  AST_SCLK_OE: assert property (sclk_oe_n == !(tcm[7] && tcm[4]))
    else $error("clock drive wrong");
  AST_RDY_FALL: assert property ($fell(rx_data_ready) |-> $past(acc && !pwrite && paddr == 12'h004))
    else $error("buffer emptied without read");
  AST_WAKE: assert property (wake_event |-> $past(bcm[1]) ##1 !wake_event)
    else $error("wake pulse wrong");
endmodule : spb_checker
`default_nettype wire

// ===== verif/spb_remote_node.sv
// remote asynchronous transmitter driving the receive line
`timescale 1ns/100ps
`default_nettype none
module spb_remote_node (
  input wire logic pclk,
  input wire logic go,
  input wire logic [10:0] frm,
  input wire logic [3:0] nb,
  input wire logic [15:0] bitc,
  input wire logic inv,
  output logic rx_line,
  output logic busy
);
  logic [10:0] sh;
  logic [3:0] left;
  logic [15:0] cnt;
  initial busy = 1'b0;
  // frame word carries start, data lsb first and stop; each bit held bitc cycles
  always @(posedge pclk) begin
    if (!busy) begin
      if (go) begin
        sh <= frm;
        left <= nb;
        cnt <= bitc;
        busy <= 1'b1;
      end
    end else if (cnt == 16'h1) begin
      cnt <= bitc;
      sh <= {1'b1, sh[10:1]};
      left <= left - 4'h1;
      if (left == 4'h1) busy <= 1'b0;
    end else begin
      cnt <= cnt - 16'h1;
    end
  end
  // idle line is high before the inverter
  assign rx_line = (busy ? sh[0] : 1'b1) ^ inv;
endmodule : spb_remote_node
`default_nettype wire

// ===== verif/tb_serial_port_baud_and_rx_status.sv
// self-checking bench for the serial port baud and receive status block
`timescale 1ns/100ps
`default_nettype none
module tb_serial_port_baud_and_rx_status;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, rx_pin, tx_line, tx_pin;
  logic sclk_in, sclk_seen, sclk_out, sclk_oe_n, rx_data_ready, wake_event;
  logic go, inv, busy, prv, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, nb;
  logic [10:0] frm;
  logic [15:0] bitc;
  int n_fail = 0;
  int checked = 0;
  int wakes = 0;
  int i;
  typedef struct packed {
    logic [7:0] tc, bc, dv, rs;
    logic [15:0] cyc;
    logic [10:0] f;
    logic [3:0] n;
    logic iv;
    logic [7:0] st;
    logic rdy;
    logic [7:0] d;
  } spb_row_s;
  // tc, bc, div, status cfg, bit cycles, frame, bits, invert, status, ready, data
  spb_row_s rows [5] = '{
    '{8'h00, 8'h00, 8'h00, 8'h50, 16'h0040, 11'h54a, 4'hb, 1'b0, 8'h50, 1'b1, 8'ha5},
    '{8'h04, 8'h00, 8'h01, 8'h50, 16'h0020, 11'h678, 4'hb, 1'b0, 8'h51, 1'b1, 8'h3c},
    '{8'h04, 8'h00, 8'h01, 8'h58, 16'h0020, 11'h586, 4'hb, 1'b0, 8'h59, 1'b0, 8'h00},
    '{8'h00, 8'h08, 8'h03, 8'h50, 16'h0040, 11'h0b4, 4'hb, 1'b0, 8'h54, 1'b1, 8'h5a},
    '{8'h04, 8'h20, 8'h01, 8'h50, 16'h0020, 11'h7ce, 4'hb, 1'b1, 8'h51, 1'b1, 8'he7}};
  spb_serial_port u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_pin(rx_pin), .tx_line(tx_line), .tx_pin(tx_pin),
    .sclk_in(sclk_in), .sclk_seen(sclk_seen), .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n),
    .rx_data_ready(rx_data_ready), .wake_event(wake_event));
  spb_remote_node u_node (.pclk(pclk), .go(go), .frm(frm), .nb(nb), .bitc(bitc), .inv(inv),
    .rx_line(rx_pin), .busy(busy));
  // *****************
  // clock and helpers
  // *****************
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // transmit line held high through reset so the pin starts idle
  always @(posedge pclk) tx_line <= !presetn || !tx_line;
  always @(posedge pclk) sclk_in <= !sclk_in;
  always @(posedge pclk) prv <= sclk_out;
  always @(posedge pclk) if (wake_event === 1'b1) wakes <= wakes + 1;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // one apb transfer; read data and error taken at the ready edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 100);
    // a slave that never answers counts against the run
    if (pready !== 1'b1) n_fail++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // frame from the remote node, idle flag probed mid-frame
  task automatic send(input logic [10:0] f, input logic [15:0] c, input logic ck);
    int k;
    frm <= f;
    nb <= 4'hb;
    bitc <= c;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    repeat (3 * c) @(posedge pclk);
    apb(1'b0, 12'h00c, 32'h0);
    if (ck) chk(32'(rd[6]), 32'h0);
    k = 0;
    while (busy !== 1'b0 && k < 40000) begin
      @(posedge pclk);
      k++;
    end
    if (busy !== 1'b0) n_fail++;
    repeat (c / 2) @(posedge pclk);
  endtask : send
  // sync clock period, second rising edge gives a full period
  task automatic per(input int e);
    int n;
    int m;
    for (m = 0; m < 2; m++) begin
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (!(sclk_out === 1'b1 && prv === 1'b0) && n < 3000);
    end
    chk(n, e);
  endtask : per
  task automatic complete_run;
    $display("checks=%0d failures=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : complete_run
  initial begin
    #400000;
    n_fail++;
    complete_run;
  end
  // ***********
  // main flow
  // ***********
  initial begin
    {presetn, psel, penable, pwrite, go, inv, sclk_in, tx_line} = 8'h01;
    {paddr, pwdata, pstrb, frm, nb, bitc} = '0;
    pstrb = 4'h1;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    // receiver off while polarity and rate change, so no false start
    for (i = 0; i < 5; i++) begin
      apb(1'b1, 12'h000, 32'h0);
      inv <= rows[i].iv;
      apb(1'b1, 12'h008, 32'(rows[i].tc));
      apb(1'b1, 12'h00c, 32'(rows[i].bc));
      apb(1'b1, 12'h010, 32'(rows[i].dv));
      apb(1'b1, 12'h000, 32'(rows[i].rs));
      send(rows[i].f, rows[i].cyc, 1'b1);
      chk(32'(rx_data_ready), 32'(rows[i].rdy));
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'(rows[i].st));
      if (rows[i].rdy) begin
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'(rows[i].d));
      end
    end
    inv <= 1'b0;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd, 32'h40);
    apb(1'b0, 12'h018, 32'h0);
    chk(32'(er), 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, 12'h00c, 32'h94);
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd, 32'hd0);
    apb(1'b1, 12'h00c, 32'h00);
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd, 32'h40);
    apb(1'b1, 12'h008, 32'h94);
    apb(1'b1, 12'h014, 32'h01);
    apb(1'b1, 12'h010, 32'h02);
    per(12);
    apb(1'b1, 12'h00c, 32'h08);
    per(1036);
    apb(1'b1, 12'h008, 32'h04);
    apb(1'b1, 12'h00c, 32'h00);
    apb(1'b1, 12'h010, 32'h01);
    apb(1'b1, 12'h000, 32'h50);
    send(11'h678, 16'h0020, 1'b1);
    send(11'h678, 16'h0020, 1'b1);
    apb(1'b0, 12'h000, 32'h0);
    chk(32'(rd[1]), 32'h1);
    apb(1'b1, 12'h000, 32'h40);
    apb(1'b0, 12'h000, 32'h0);
    chk(32'(rd[1]), 32'h0);
    apb(1'b1, 12'h00c, 32'h02);
    apb(1'b1, 12'h000, 32'h50);
    send(11'h400, 16'h0020, 1'b0);
    chk(wakes, 1);
    apb(1'b0, 12'h00c, 32'h0);
    chk(32'(rd[1]), 32'h0);
    // autobaud on a 55h character at 256 cycles per bit, sixteen ticks per bit
    apb(1'b1, 12'h00c, 32'h01);
    send(11'h6aa, 16'h0100, 1'b0);
    apb(1'b0, 12'h010, 32'h0);
    chk(rd, 32'h0f);
    apb(1'b0, 12'h014, 32'h0);
    chk(rd, 32'h00);
    apb(1'b0, 12'h00c, 32'h0);
    chk(rd, 32'h40);
    complete_run;
  end
endmodule : tb_serial_port_baud_and_rx_status
bind spb_serial_port spb_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_line(tx_line), .tx_pin(tx_pin),
  .sclk_in(sclk_in), .sclk_seen(sclk_seen), .sclk_oe_n(sclk_oe_n),
  .rx_data_ready(rx_data_ready), .wake_event(wake_event));
`default_nettype wire
